/* windowed_watchdog_timer.sv */
// Purpose: Windowed watchdog timer on a slow RC clock, Wishbone registers
// Assumes: All inputs synchronous to CLK_I; slow clock sampled as a level
// Notes:   Event inputs from the core are one-cycle pulses
//
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "wdt_consts.svh"

module windowed_watchdog_timer
	import wdt_pkg::*;
(
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        CE_I,
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [5:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	input  wire logic        LOW_POWER_RC_OSC_I,
	output logic             LOW_POWER_RC_OSC_EN_O,
	input  wire logic        CLEAR_WATCHDOG_INSTR_I,
	input  wire logic        SLEEP_ENTER_I,
	input  wire logic        IDLE_ENTER_I,
	input  wire logic        POWER_SAVE_EXIT_I,
	input  wire logic        CLOCK_SWITCH_DONE_I,
	output logic             WATCHDOG_RESET_O,
	output logic             WAKE_O,
	output logic             IRQ_O
);

	logic [7:0]            watchdog_config_word;
	logic                  sw_watchdog_enable;
	logic                  watchdog_timeout_flag;
	logic                  sleep_flag;
	logic                  idle_flag;
	logic [`IRQ_W-1:0]     int_status;
	logic [`IRQ_W-1:0]     int_mask;
	logic [`PRE_W-1:0]     pre_count;
	logic [`POST_W-1:0]    post_count;
	logic                  osc_prev;
	power_mode_e           mode;

	logic                  bus_req;
	logic                  wr_low;
	logic                  hw_watchdog_enable;
	logic                  window_disable;
	logic                  prescale_select;
	logic [3:0]            postscale_select;
	logic                  enabled;
	logic                  tick;
	logic [`PRE_W-1:0]     pre_last;
	logic [`POST_W-1:0]    post_last;
	logic                  pre_wrap;
	logic                  expire;
	logic [`ELAPSED_W-1:0] elapsed;
	logic [`ELAPSED_W-1:0] period;
	logic                  win_open;
	logic [`ELAPSED_W-1:0] win_start;
	logic                  in_run;
	logic                  clr_ok;
	logic                  clr_early;
	logic                  power_save_enter;
	logic                  power_save_leave;
	logic                  restart;
	logic                  run_timeout;
	logic                  ps_timeout;
	logic [`IRQ_W-1:0]     events;
	logic [31:0]           next_dat;

	// Configuration fields
	assign hw_watchdog_enable = watchdog_config_word[`CFG_HW_EN_BIT];
	assign window_disable     = watchdog_config_word[`CFG_WINDOW_DIS_BIT];
	assign prescale_select    = watchdog_config_word[`CFG_PRESCALE_BIT];
	assign postscale_select   = watchdog_config_word[`CFG_POST_HI:`CFG_POST_LO];

	assign bus_req = CYC_I & STB_I & ~ACK_O;
	assign wr_low  = bus_req & WE_I & SEL_I[0];

	// Enable source
	assign enabled               = hw_watchdog_enable | sw_watchdog_enable;
	assign LOW_POWER_RC_OSC_EN_O = enabled;

	// Rising edge of slow clock
	assign tick = LOW_POWER_RC_OSC_I & ~osc_prev;

	// Divider terminal counts
	assign pre_last  = prescale_select ? `PRE_DIV_7BIT : `PRE_DIV_5BIT;
	assign post_last = `POST_W'((`POST_W+1)'(1) << postscale_select) - `POST_W'(1);
	assign pre_wrap  = tick & (pre_count == pre_last);
	assign expire    = enabled & pre_wrap & (post_count == post_last);

	// Time elapsed in slow clock ticks
	always_comb begin
		if (prescale_select) begin
			elapsed = (`ELAPSED_W'(post_count) << `PRE_SHIFT_7BIT) | `ELAPSED_W'(pre_count);
		end else begin
			elapsed = (`ELAPSED_W'(post_count) << `PRE_SHIFT_5BIT)
				| `ELAPSED_W'(pre_count[`PRE_SHIFT_5BIT-1:0]);
		end
	end

	// Full period in slow clock ticks
	always_comb begin
		if (prescale_select) begin
			period = `ELAPSED_W'(1) << (`PRE_SHIFT_7BIT + 32'(postscale_select));
		end else begin
			period = `ELAPSED_W'(1) << (`PRE_SHIFT_5BIT + 32'(postscale_select));
		end
	end

	// Last quarter of the period
	assign win_start = period - (period >> 2);
	assign win_open  = elapsed >= win_start;

	// Normal execution
	assign in_run = (mode == MODE_RUN);

	// Clear instruction handling
	assign clr_ok    = CLEAR_WATCHDOG_INSTR_I & in_run
		& (window_disable | win_open);
	assign clr_early = CLEAR_WATCHDOG_INSTR_I & in_run & enabled
		& ~window_disable & ~win_open;

	assign power_save_enter = in_run & (SLEEP_ENTER_I | IDLE_ENTER_I);
	assign power_save_leave = ~in_run & (POWER_SAVE_EXIT_I | expire);

	assign run_timeout = (expire & in_run) | clr_early;
	assign ps_timeout  = expire & ~in_run;

	assign restart = ~enabled | CLOCK_SWITCH_DONE_I | power_save_enter
		| power_save_leave | clr_ok | clr_early | expire;

	// Slow clock edge detector
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			osc_prev <= 1'b0;
		end else if (CE_I) begin
			osc_prev <= LOW_POWER_RC_OSC_I;
		end
	end

	// Prescaler
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			pre_count <= '0;
		end else if (CE_I) begin
			if (restart) begin
				pre_count <= '0;
			end else if (tick) begin
				if (pre_wrap) begin
					pre_count <= '0;
				end else begin
					pre_count <= pre_count + `PRE_W'(1);
				end
			end
		end
	end

	// Postscaler
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			post_count <= '0;
		end else if (CE_I) begin
			if (restart) begin
				post_count <= '0;
			end else if (pre_wrap) begin
				post_count <= post_count + `POST_W'(1);
			end
		end
	end

	// Power mode tracking
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			mode <= MODE_RUN;
		end else if (CE_I) begin
			case (mode)
				MODE_RUN: begin
					if (SLEEP_ENTER_I) begin
						mode <= MODE_SLEEP;
					end else if (IDLE_ENTER_I) begin
						mode <= MODE_IDLE;
					end
				end
				MODE_SLEEP, MODE_IDLE: begin
					if (power_save_leave) begin
						mode <= MODE_RUN;
					end
				end
				default: begin
					mode <= MODE_RUN;
				end
			endcase
		end
	end

	// Watchdog reset pulse
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			WATCHDOG_RESET_O <= 1'b0;
		end else if (CE_I) begin
			WATCHDOG_RESET_O <= run_timeout;
		end
	end

	// Wake pulse
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			WAKE_O <= 1'b0;
		end else if (CE_I) begin
			WAKE_O <= ps_timeout;
		end
	end

	// Configuration word
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			watchdog_config_word <= `CFG_RESET_VAL;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_CONFIG) begin
				watchdog_config_word <= DAT_I[7:0];
			end
		end
	end

	// Software enable bit
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			sw_watchdog_enable <= 1'b0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_RESET_CTRL) begin
				sw_watchdog_enable <= DAT_I[`RC_SW_EN_BIT];
			end
		end
	end

	// Timeout flag; a set wins over a software clear
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			watchdog_timeout_flag <= 1'b0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_RESET_CTRL) begin
				watchdog_timeout_flag <= (watchdog_timeout_flag & DAT_I[`RC_TIMEOUT_BIT])
					| run_timeout | ps_timeout;
			end else begin
				watchdog_timeout_flag <= watchdog_timeout_flag | run_timeout | ps_timeout;
			end
		end
	end

	// Sleep status bit; a set wins
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			sleep_flag <= 1'b0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_RESET_CTRL) begin
				sleep_flag <= (sleep_flag & DAT_I[`RC_SLEEP_BIT])
					| (power_save_enter & SLEEP_ENTER_I);
			end else begin
				sleep_flag <= sleep_flag | (power_save_enter & SLEEP_ENTER_I);
			end
		end
	end

	// Idle status bit; a set wins
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			idle_flag <= 1'b0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_RESET_CTRL) begin
				idle_flag <= (idle_flag & DAT_I[`RC_IDLE_BIT])
					| (power_save_enter & ~SLEEP_ENTER_I);
			end else begin
				idle_flag <= idle_flag | (power_save_enter & ~SLEEP_ENTER_I);
			end
		end
	end

	// Interrupt events
	assign events = {clr_early, ps_timeout, run_timeout};

	// Interrupt status; a set wins
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			int_status <= '0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_INT_STATUS) begin
				int_status <= (int_status & ~DAT_I[`IRQ_W-1:0]) | events;
			end else begin
				int_status <= int_status | events;
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			int_mask <= '0;
		end else if (CE_I) begin
			if (wr_low && ADR_I == `WDT_ADR_INT_MASK) begin
				int_mask <= DAT_I[`IRQ_W-1:0];
			end
		end
	end

	assign IRQ_O = |(int_status & int_mask);

	// Read data selection
	always_comb begin
		next_dat = '0;
		case (ADR_I)
			`WDT_ADR_CONFIG: begin
				next_dat[7:0] = watchdog_config_word;
			end
			`WDT_ADR_RESET_CTRL: begin
				next_dat[`RC_SW_EN_BIT]   = sw_watchdog_enable;
				next_dat[`RC_TIMEOUT_BIT] = watchdog_timeout_flag;
				next_dat[`RC_SLEEP_BIT]   = sleep_flag;
				next_dat[`RC_IDLE_BIT]    = idle_flag;
			end
			`WDT_ADR_INT_STATUS: begin
				next_dat[`IRQ_W-1:0] = int_status;
			end
			`WDT_ADR_INT_MASK: begin
				next_dat[`IRQ_W-1:0] = int_mask;
			end
			`WDT_ADR_COUNT: begin
				next_dat[`PRE_W-1:0]              = pre_count;
				next_dat[`PRE_W+`POST_W-1:`PRE_W] = post_count;
				next_dat[`CNT_MODE_HI:`CNT_MODE_LO] = mode;
				next_dat[`CNT_WIN_BIT]              = win_open;
			end
			default: begin
				next_dat = '0;
			end
		endcase
	end

	// Wishbone acknowledge
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			ACK_O <= 1'b0;
		end else if (CE_I) begin
			ACK_O <= bus_req;
		end
	end

	// Registered read data, zero outside ack
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			DAT_O <= '0;
		end else if (CE_I) begin
			DAT_O <= bus_req ? next_dat : '0;
		end
	end

endmodule : windowed_watchdog_timer

/* wdt_consts.svh */
// Purpose: Named constants for the windowed watchdog timer
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses
// Notes:   Included by the watchdog module
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// Register byte offsets
`define WDT_ADR_CONFIG        6'h00
`define WDT_ADR_RESET_CTRL    6'h04
`define WDT_ADR_INT_STATUS    6'h08
`define WDT_ADR_INT_MASK      6'h0C
`define WDT_ADR_COUNT         6'h10
`define WDT_ADR_W             6

// Configuration word fields
`define CFG_POST_LO           0
`define CFG_POST_HI           3
`define CFG_PRESCALE_BIT      4
`define CFG_WINDOW_DIS_BIT    6
`define CFG_HW_EN_BIT         7
`define CFG_RESET_VAL         8'h5F

// Reset control register fields
`define RC_IDLE_BIT           2
`define RC_SLEEP_BIT          3
`define RC_TIMEOUT_BIT        4
`define RC_SW_EN_BIT          5

// Count register fields
`define CNT_MODE_LO           22
`define CNT_MODE_HI           23
`define CNT_WIN_BIT           24

// Interrupt status and mask fields
`define IRQ_TIMEOUT_BIT       0
`define IRQ_WAKE_BIT          1
`define IRQ_WINDOW_BIT        2
`define IRQ_W                 3

// Prescaler and postscaler
`define PRE_W                 7
`define POST_W                15
`define ELAPSED_W             23
`define PRE_DIV_5BIT          7'h1F
`define PRE_DIV_7BIT          7'h7F
`define PRE_SHIFT_5BIT        5
`define PRE_SHIFT_7BIT        7

// Nominal figures of the slow clock
`define LOW_POWER_RC_OSC_NOM_HZ           31000
`define BASE_PERIOD_5BIT_US   1000
`define BASE_PERIOD_7BIT_US   4000

`endif

/* wdt_pkg.sv */
// Purpose: Types for the windowed watchdog timer
// Assumes: wdt_consts.svh holds all numeric constants
// Notes:   Power mode as seen by the watchdog
package wdt_pkg;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_IDLE  = 2'b10
	} power_mode_e;

endpackage : wdt_pkg

/* wdt_osc_model.sv */
// Purpose: Slow RC oscillator feeding the watchdog
// Assumes: Stands low while not enabled
// Notes:   One rising edge every four clocks
`timescale 1ns/10ps
module wdt_osc_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	output logic             osc_o,
	output logic [15:0]      ticks_o
);
	logic [1:0] ph;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || !en_i) begin
			ph <= 2'h0;
			osc_o <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			osc_o <= (ph == 2'h1) || (ph == 2'h2);
		end
	end
	always_ff @(posedge clk_i) begin
		if (!rst_n_i)
			ticks_o <= 16'h0000;
		else if (en_i && ph == 2'h1)
			ticks_o <= ticks_o + 16'h0001;
	end
endmodule : wdt_osc_model

/* wdt_asserts.sv */
// Purpose: Port checks for the watchdog
// Assumes: Bound to the watchdog top
// Notes:   One clock domain
`timescale 1ns/10ps
module wdt_asserts (
	input wire logic        CLK_I,
	input wire logic        RST_N_I,
	input wire logic        CE_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic        ACK_O,
	input wire logic [31:0] DAT_O,
	input wire logic        LOW_POWER_RC_OSC_EN_O,
	input wire logic        WATCHDOG_RESET_O,
	input wire logic        WAKE_O,
	input wire logic        IRQ_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);
	property p_ack; CYC_I && STB_I && !ACK_O && CE_I |=> ACK_O; endproperty
	a_ack: assert property (p_ack) else $error("request not acked");
	property p_ack1; ACK_O |=> !ACK_O; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_dat0; !ACK_O |-> DAT_O == 32'h0; endproperty
	a_dat0: assert property (p_dat0) else $error("data outside ack");
	property p_rst1; WATCHDOG_RESET_O |=> !WATCHDOG_RESET_O; endproperty
	a_rst1: assert property (p_rst1) else $error("reset pulse long");
	property p_wake1; WAKE_O |=> !WAKE_O; endproperty
	a_wake1: assert property (p_wake1) else $error("wake pulse long");
	property p_excl; !(WAKE_O && WATCHDOG_RESET_O); endproperty
	a_excl: assert property (p_excl) else $error("wake with reset");
	property p_gate; !$past(LOW_POWER_RC_OSC_EN_O) |-> !WATCHDOG_RESET_O && !WAKE_O; endproperty
	a_gate: assert property (p_gate) else $error("event while off");
	property p_swoff; $rose(RST_N_I) |-> !LOW_POWER_RC_OSC_EN_O; endproperty
	a_swoff: assert property (p_swoff) else $error("enabled after reset");
	c_rst: cover property (WATCHDOG_RESET_O);
	c_wake: cover property (WAKE_O);
	c_irq: cover property (IRQ_O);
endmodule : wdt_asserts
bind windowed_watchdog_timer wdt_asserts u_chk (.CLK_I, .RST_N_I, .CE_I, .CYC_I,
	.STB_I, .ACK_O, .DAT_O, .LOW_POWER_RC_OSC_EN_O, .WATCHDOG_RESET_O, .WAKE_O, .IRQ_O);

/* testbench.sv */
// Purpose: Self-checking bench for the watchdog
// Assumes: Osc model ticks every four clocks
// Notes:   Events {clear,sleep,idle,exit,switch}
`timescale 1ns/10ps
`define CHK(n,e,a) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
	$display("[ERR] %s exp %0h got %0h", n, e, a); end end
module testbench;
	logic clk, rst_n = 0, cyc = 0, stb = 0, we = 0, r, w;
	logic [5:0] adr = 6'h00;
	logic [31:0] dat = 32'h0, q;
	logic [4:0] ev = 5'h00;
	logic [15:0] ticks;
	logic [31:0] dat_o;
	logic ack, osc, osc_en, wrst, wake, irq;
	int mismatches = 0, checks_done = 0, nrst = 0, t, n0;
	windowed_watchdog_timer DUT (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .CYC_I(cyc),
		.STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o),
		.ACK_O(ack), .LOW_POWER_RC_OSC_I(osc), .LOW_POWER_RC_OSC_EN_O(osc_en),
		.CLEAR_WATCHDOG_INSTR_I(ev[4]), .SLEEP_ENTER_I(ev[3]), .IDLE_ENTER_I(ev[2]),
		.POWER_SAVE_EXIT_I(ev[1]), .CLOCK_SWITCH_DONE_I(ev[0]),
		.WATCHDOG_RESET_O(wrst), .WAKE_O(wake), .IRQ_O(irq));
	wdt_osc_model u_osc (.clk_i(clk), .rst_n_i(rst_n), .en_i(osc_en), .osc_o(osc),
		.ticks_o(ticks));
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) if (wrst === 1'b1) nrst++;
	task automatic bus(input logic [5:0] a, input logic wr, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		`CHK("reg", e, q)
	endtask : rd
	task automatic pulse(input logic [4:0] m);
		ev <= m;
		@(posedge clk);
		ev <= 5'h00;
	endtask : pulse
	task automatic waitp();
		int n = 0;
		t = ticks;
		do begin @(posedge clk); n++; end while (wrst !== 1 && wake !== 1 && n < 3000);
		r = wrst;
		w = wake;
		t = ticks - t;
	endtask : waitp
	task automatic t_run();
		bus(6'h00, 1, 32'h40);
		bus(6'h04, 1, 32'h20);
		`CHK("osc_en", 1'b1, osc_en)
		waitp();
		`CHK("reset", 1'b1, r)
		`CHK("ticks", 1'b1, t >= 31 && t <= 32)
		rd(6'h04, 32'h30);
		bus(6'h04, 1, 32'h20);
		rd(6'h04, 32'h20);
		n0 = nrst;
		for (int i = 0; i < 6; i++) begin
			repeat (80) @(posedge clk);
			pulse(i[0] ? 5'h10 : 5'h01);
		end
		`CHK("kept", n0, nrst)
	endtask : t_run
	task automatic t_sleep(input logic [4:0] m);
		pulse(m);
		@(posedge clk);
		waitp();
		`CHK("wake", 2'b01, {r, w})
		rd(6'h04, {27'h0, m} | 32'h30);
		bus(6'h04, 1, 32'h20);
	endtask : t_sleep
	task automatic t_exit();
		pulse(5'h08);
		repeat (60) @(posedge clk);
		pulse(5'h02);
		@(posedge clk);
		bus(6'h10, 1'b0, 32'h0);
		`CHK("mode", 2'b00, q[23:22])
		waitp();
		`CHK("exit", 2'b10, {r, w})
		`CHK("restart", 1'b1, t >= 30 && t <= 32)
		bus(6'h04, 1, 32'h20);
	endtask : t_exit
	task automatic t_window();
		bus(6'h00, 1, 32'h00);
		pulse(5'h10);
		@(posedge clk);
		`CHK("early", 1'b1, wrst)
		repeat (110) @(posedge clk);
		n0 = nrst;
		pulse(5'h10);
		repeat (60) @(posedge clk);
		`CHK("late", n0, nrst)
		bus(6'h04, 1, 32'h00);
		rd(6'h08, 32'h7);
	endtask : t_window
	task automatic t_irq();
		bus(6'h0C, 1, 32'h7);
		`CHK("irq", 1'b1, irq)
		bus(6'h0C, 1, 32'h0);
		`CHK("irq", 1'b0, irq)
		bus(6'h08, 1, 32'h7);
		rd(6'h08, 32'h0);
		rd(6'h3C, 32'h0);
		bus(6'h00, 1, 32'hC0);
		`CHK("hw_en", 1'b1, osc_en)
		bus(6'h00, 1, 32'h40);
		`CHK("hw_en", 1'b0, osc_en)
	endtask : t_irq
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : summarize
	initial begin
		#400000;
		mismatches++;
		summarize();
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(6'h00, 32'h5F);
		rd(6'h04, 32'h0);
		t_run();
		t_sleep(5'h08);
		t_sleep(5'h04);
		t_exit();
		t_window();
		t_irq();
		bus(6'h04, 1, 32'h20);
		rst_n <= 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		rd(6'h04, 32'h0);
		summarize();
	end
endmodule : testbench
